// ==== common/sar_link_regs.svh ====
// Timing and field constants shared by both ends of the converter link.
// Assumes a 250 MHz system clock on each end.
`ifndef SAR_LINK_REGS_SVH
`define SAR_LINK_REGS_SVH
`define CLK_PERIOD_NS 4
`define CONV_TIME_NS 800
`define ACQ_TIME_NS 200
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACQ_CYCLES ((`ACQ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WORD_BITS 5'h10
`define LAST_BIT 5'h0F
`define MQUARTER 8'h02
`define MPH_RISE 2'h1
`define MPH_HIGH 2'h2
`define MPH_FALL 2'h3
`define CNV_PULSE 8'h04
`define HSCLK_HALF 8'h10
`define PAR_SETTLE 8'h08
`endif

// ==== common/sar_link_pkg.sv ====
// Types shared by the converter end and the host end.
// Assumes sar_link_regs.svh for the numeric constants.
package sar_link_pkg;
  typedef enum logic [1:0] {
    SPEED_WARP = 2'h0, SPEED_NORMAL = 2'h1, SPEED_IMPULSE = 2'h2
  } speed_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_CONV = 2'h1, ST_ACQ = 2'h2, ST_MXFER = 2'h3
  } dev_state_type;
  typedef enum logic [1:0] {
    H_IDLE = 2'h0, H_CNV = 2'h1, H_WAIT = 2'h2, H_READ = 2'h3
  } host_state_type;
endpackage : sar_link_pkg

// ==== common/sar_link_if.sv ====
// Pin bundle between the converter readout logic and its host.
// Assumes the bench resolves shared wires from the enables.
`timescale 1ns/10ps
interface sar_link_if;
  logic convert_start_n;
  logic power_down_input;
  logic cs_n;
  logic rd_n;
  logic serial_parallel_select;
  logic byte_order_select;
  logic output_coding_select;
  logic clock_source_select;
  logic read_mode_or_chain_in;
  logic sclk_invert;
  logic sync_invert;
  logic [1:0] speed_mode;
  logic ext_sclk;
  logic [15:0] data_out;
  logic data_oe;
  logic serial_result_out;
  logic serial_oe;
  logic master_sclk;
  logic master_sclk_oe;
  logic sync_out;
  logic sync_oe;
  logic busy;
  logic read_overrun_flag;
  modport device (
    input convert_start_n, power_down_input, cs_n, rd_n, serial_parallel_select,
    input byte_order_select, output_coding_select, clock_source_select,
    input read_mode_or_chain_in, sclk_invert, sync_invert, speed_mode, ext_sclk,
    output data_out, data_oe, serial_result_out, serial_oe, master_sclk,
    output master_sclk_oe, sync_out, sync_oe, busy, read_overrun_flag
  );
  modport host (
    output convert_start_n, power_down_input, cs_n, rd_n, serial_parallel_select,
    output byte_order_select, output_coding_select, clock_source_select,
    output read_mode_or_chain_in, sclk_invert, sync_invert, speed_mode, ext_sclk,
    input data_out, data_oe, serial_result_out, serial_oe, master_sclk,
    input master_sclk_oe, sync_out, sync_oe, busy, read_overrun_flag
  );
endinterface : sar_link_if

// ==== logic/edge_sync.sv ====
// Two-flop synchroniser with edge detection behind the second flop.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/10ps
module edge_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous inputs
  input wire logic [WIDTH-1:0] din,
  // Synchronised level and edges
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] stable_reg;
  logic [WIDTH-1:0] prev_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      stable_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= din;
      stable_reg <= meta_reg;
      prev_reg <= stable_reg;
    end
  end

  assign level = stable_reg;
  assign rise = stable_reg & ~prev_reg;
  assign fall = ~stable_reg & prev_reg;
endmodule : edge_sync

// ==== logic/sar_readout_device.sv ====
// Conversion control and result readout of the converter end.
// Assumes all link inputs are asynchronous and the core result is stable
// at the end of each conversion.
`timescale 1ns/10ps
`include "sar_link_regs.svh"
module sar_readout_device (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins toward the host
  sar_link_if.device link,
  // Converter core
  input wire logic [15:0] sample_value,
  output logic low_power_idle
);
  logic [13:0] pin_lvl;
  logic [13:0] pin_rise;
  logic [13:0] pin_fall;
  logic cnv_n, cnv_fall, cs_n, rd_n, sclk_lvl, sclk_rise, sclk_fall;
  logic ser, swap, straight, ext_src, rd_during, sclk_inv, sync_inv, pd;
  logic impulse, sel, master, repeat_ok, master_after, conv_start, conv_end;
  logic s_active, ret_edge, m_start, m_done;
  sar_link_pkg::dev_state_type state_reg, state_next;
  logic [7:0] timer_reg;
  logic [15:0] result_reg;
  logic have_result_reg;
  logic [15:0] s_shift_reg;
  logic [4:0] s_cnt_reg;
  logic s_idle_reg, s_dur_reg;
  logic m_active_reg;
  logic [1:0] m_phase_reg;
  logic [7:0] m_div_reg;
  logic [4:0] m_cnt_reg;
  logic [15:0] m_shift_reg;

  function automatic logic [15:0] code_result(input logic [15:0] raw, input logic bin);
    code_result = bin ? raw : {~raw[15], raw[14:0]};
  endfunction : code_result

  edge_sync #(.WIDTH(14)) pin_sync (
    .clk(clk),
    .rst(rst),
    .din({link.convert_start_n, link.cs_n, link.rd_n, link.ext_sclk,
          link.serial_parallel_select, link.byte_order_select,
          link.output_coding_select, link.clock_source_select,
          link.read_mode_or_chain_in, link.sclk_invert, link.sync_invert,
          link.speed_mode, link.power_down_input}),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign cnv_n = pin_lvl[13];
  assign cnv_fall = pin_fall[13];
  assign cs_n = pin_lvl[12];
  assign rd_n = pin_lvl[11];
  assign sclk_lvl = pin_lvl[10];
  assign sclk_rise = pin_rise[10];
  assign sclk_fall = pin_fall[10];
  assign ser = pin_lvl[9];
  assign swap = pin_lvl[8];
  assign straight = pin_lvl[7];
  assign ext_src = pin_lvl[6];
  assign rd_during = pin_lvl[5];
  assign sclk_inv = pin_lvl[4];
  assign sync_inv = pin_lvl[3];
  assign pd = pin_lvl[0];
  assign impulse = (pin_lvl[2:1] == sar_link_pkg::SPEED_IMPULSE);

  assign sel = !cs_n && !rd_n;
  assign master = ser && !ext_src;
  assign repeat_ok = impulse && !cnv_n;
  assign master_after = master && !rd_during;

  // Conversion sequencer; start pin is read without regard to select or read
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sar_link_pkg::ST_IDLE: begin
        if (cnv_fall && !pd) state_next = sar_link_pkg::ST_CONV;
      end
      sar_link_pkg::ST_CONV: begin
        // Neither start nor power-down can cut this short
        if (timer_reg == 8'h00) begin
          if (master_after) state_next = sar_link_pkg::ST_MXFER;
          else if (repeat_ok) state_next = sar_link_pkg::ST_ACQ;
          else state_next = sar_link_pkg::ST_IDLE;
        end
      end
      sar_link_pkg::ST_ACQ: begin
        if (!repeat_ok) state_next = sar_link_pkg::ST_IDLE;
        else if (timer_reg == 8'h00) state_next = sar_link_pkg::ST_CONV;
      end
      sar_link_pkg::ST_MXFER: begin
        if (m_done || !m_active_reg) begin
          state_next = repeat_ok ? sar_link_pkg::ST_ACQ : sar_link_pkg::ST_IDLE;
        end
      end
      default: state_next = sar_link_pkg::ST_IDLE;
    endcase
  end

  assign conv_start = (state_next == sar_link_pkg::ST_CONV) && (state_reg != sar_link_pkg::ST_CONV);
  assign conv_end = (state_reg == sar_link_pkg::ST_CONV) && (state_next != sar_link_pkg::ST_CONV);

  always_ff @(posedge clk) begin
    if (rst) state_reg <= sar_link_pkg::ST_IDLE;
    else state_reg <= state_next;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timer_reg <= 8'h00;
    end else if (conv_start) begin
      timer_reg <= 8'(`CONV_CYCLES - 1);
    end else if (state_next == sar_link_pkg::ST_ACQ && state_reg != sar_link_pkg::ST_ACQ) begin
      timer_reg <= 8'(`ACQ_CYCLES - 1);
    end else if (timer_reg != 8'h00) begin
      timer_reg <= timer_reg - 8'h01;
    end
  end

  // Result stays put through the next conversion so it can be read then
  always_ff @(posedge clk) begin
    if (rst) begin
      result_reg <= 16'h0000;
      have_result_reg <= 1'b0;
    end else if (conv_end) begin
      result_reg <= code_result(sample_value, straight);
      have_result_reg <= 1'b1;
    end
  end

  // Slave shifter: advances on the edge that returns the clock to its idle
  // level, so each bit spans a whole pulse. A free-running clock gives an
  // arbitrary idle level, so the first pulse after select may be partial.
  assign s_active = sel && ser && ext_src;
  assign ret_edge = s_idle_reg ? sclk_rise : sclk_fall;

  always_ff @(posedge clk) begin
    if (rst) begin
      s_shift_reg <= 16'h0000;
      s_cnt_reg <= 5'h00;
      s_idle_reg <= 1'b0;
      s_dur_reg <= 1'b0;
    end else if (!s_active) begin
      s_shift_reg <= result_reg;
      s_cnt_reg <= 5'h00;
      s_idle_reg <= sclk_lvl;
      s_dur_reg <= 1'b0;
    end else if (ret_edge && s_cnt_reg != `WORD_BITS) begin
      s_shift_reg <= {s_shift_reg[14:0], 1'b0};
      s_cnt_reg <= s_cnt_reg + 5'h01;
      if (s_cnt_reg == 5'h00 && state_reg == sar_link_pkg::ST_CONV) s_dur_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) link.read_overrun_flag <= 1'b0;
    else link.read_overrun_flag <= conv_end && s_active && s_dur_reg && s_cnt_reg != `WORD_BITS;
  end

  // Master shifter: four phases per bit, data moves before the rise and
  // holds past the fall, so both edges land mid-bit.
  assign m_start = master && !m_active_reg &&
                   (rd_during ? (conv_start && have_result_reg) : conv_end);
  assign m_done = m_active_reg && m_div_reg == 8'h00 && m_phase_reg == `MPH_FALL &&
                  m_cnt_reg == `LAST_BIT;

  always_ff @(posedge clk) begin
    if (rst) begin
      m_active_reg <= 1'b0;
      m_phase_reg <= 2'h0;
      m_div_reg <= 8'h00;
      m_cnt_reg <= 5'h00;
      m_shift_reg <= 16'h0000;
    end else if (m_start) begin
      m_active_reg <= 1'b1;
      m_phase_reg <= 2'h0;
      m_div_reg <= `MQUARTER - 8'h01;
      m_cnt_reg <= 5'h00;
      m_shift_reg <= rd_during ? result_reg : code_result(sample_value, straight);
    end else if (m_active_reg) begin
      if (m_div_reg != 8'h00) begin
        m_div_reg <= m_div_reg - 8'h01;
      end else begin
        m_div_reg <= `MQUARTER - 8'h01;
        m_phase_reg <= m_phase_reg + 2'h1;
        if (m_phase_reg == `MPH_FALL) begin
          m_shift_reg <= {m_shift_reg[14:0], 1'b0};
          m_cnt_reg <= m_cnt_reg + 5'h01;
          if (m_cnt_reg == `LAST_BIT) m_active_reg <= 1'b0;
        end
      end
    end
  end

  // Pin drivers; every enable needs both select and read low
  always_ff @(posedge clk) begin
    if (rst) begin
      link.data_oe <= 1'b0;
      link.data_out <= 16'h0000;
      link.serial_oe <= 1'b0;
      link.serial_result_out <= 1'b0;
    end else begin
      link.data_oe <= sel && !ser;
      link.data_out <= swap ? {result_reg[7:0], result_reg[15:8]} : result_reg;
      link.serial_oe <= sel && ser;
      link.serial_result_out <= ext_src ? s_shift_reg[15] : m_shift_reg[15];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      link.master_sclk_oe <= 1'b0;
      link.master_sclk <= 1'b0;
      link.sync_oe <= 1'b0;
      link.sync_out <= 1'b0;
    end else begin
      link.master_sclk_oe <= sel && master;
      link.master_sclk <= (m_active_reg && (m_phase_reg == `MPH_RISE ||
                           m_phase_reg == `MPH_HIGH)) ^ sclk_inv;
      link.sync_oe <= sel && master;
      link.sync_out <= m_active_reg ^ sync_inv;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      link.busy <= 1'b0;
      low_power_idle <= 1'b0;
    end else begin
      link.busy <= state_next == sar_link_pkg::ST_CONV ||
                   state_next == sar_link_pkg::ST_MXFER;
      low_power_idle <= (impulse && state_next != sar_link_pkg::ST_CONV) ||
                        (pd && state_next == sar_link_pkg::ST_IDLE);
    end
  end
endmodule : sar_readout_device

// ==== logic/sar_readout_host.sv ====
// Host end: starts conversions and reads results over the link.
// Assumes the converter end on the far side of sar_link_if.
`timescale 1ns/10ps
`include "sar_link_regs.svh"
module sar_readout_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins toward the converter
  sar_link_if.host link,
  // Requests and configuration
  input wire logic start,
  input wire logic auto_repeat,
  input wire logic use_serial,
  input wire logic ext_clock,
  input wire logic read_during,
  input wire logic invert_master,
  input wire logic pd_request,
  input wire logic byte_swap,
  input wire logic straight_binary,
  input wire logic [1:0] speed,
  // Results
  output logic [15:0] result,
  output logic result_valid,
  output logic overrun_seen
);
  logic [20:0] in_lvl;
  logic [20:0] in_rise;
  logic [20:0] in_fall;
  logic busy_rise, busy_fall, sync_act, msclk_edge, host_master, hsclk_reg;
  logic sync_start;
  sar_link_pkg::host_state_type state_reg;
  logic [7:0] cnt_reg;
  logic [4:0] bits_reg;
  logic [15:0] hshift_reg;
  logic seen_reg;
  logic [4:0] mcnt_reg;
  logic [15:0] mshift_reg;

  edge_sync #(.WIDTH(21)) in_sync (
    .clk(clk),
    .rst(rst),
    .din({link.busy, link.sync_out, link.master_sclk, link.serial_result_out,
          link.read_overrun_flag, link.data_out}),
    .level(in_lvl),
    .rise(in_rise),
    .fall(in_fall)
  );

  assign busy_rise = in_rise[20];
  assign busy_fall = in_fall[20];
  assign sync_act = in_lvl[19] ^ invert_master;
  assign msclk_edge = invert_master ? in_fall[18] : in_rise[18];
  assign sync_start = invert_master ? in_fall[19] : in_rise[19];
  assign host_master = use_serial && !ext_clock;

  always_ff @(posedge clk) begin
    if (rst) begin
      link.power_down_input <= 1'b0;
      link.serial_parallel_select <= 1'b0;
      link.byte_order_select <= 1'b0;
      link.output_coding_select <= 1'b1;
      link.clock_source_select <= 1'b1;
      link.read_mode_or_chain_in <= 1'b0;
      link.sclk_invert <= 1'b0;
      link.sync_invert <= 1'b0;
      link.speed_mode <= 2'h0;
    end else begin
      link.power_down_input <= pd_request;
      link.serial_parallel_select <= use_serial;
      link.byte_order_select <= byte_swap;
      link.output_coding_select <= straight_binary;
      link.clock_source_select <= ext_clock;
      link.read_mode_or_chain_in <= read_during;
      link.sclk_invert <= invert_master;
      link.sync_invert <= invert_master;
      link.speed_mode <= speed;
    end
  end

  // Master mode keeps the port selected and collects each framed word
  always_ff @(posedge clk) begin
    if (rst) begin
      link.cs_n <= 1'b1;
      link.rd_n <= 1'b1;
      mcnt_reg <= 5'h00;
      mshift_reg <= 16'h0000;
    end else begin
      link.cs_n <= !(host_master || state_reg == sar_link_pkg::H_READ);
      link.rd_n <= !(host_master || state_reg == sar_link_pkg::H_READ);
      // Word is kept past the frame end, since busy may fall only later
      if (sync_start || state_reg == sar_link_pkg::H_CNV) begin
        mcnt_reg <= 5'h00;
      end else if (sync_act && msclk_edge && mcnt_reg != `WORD_BITS) begin
        mshift_reg <= {mshift_reg[14:0], in_lvl[17]};
        mcnt_reg <= mcnt_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) overrun_seen <= 1'b0;
    else if (in_rise[16]) overrun_seen <= 1'b1;
    else if (start && state_reg == sar_link_pkg::H_IDLE) overrun_seen <= 1'b0;
  end

  // Reads only once busy has fallen, so the external clock toggles during a
  // conversion only when a held start repeats conversions in impulse mode.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= sar_link_pkg::H_IDLE;
      link.convert_start_n <= 1'b1;
      link.ext_sclk <= 1'b0;
      hsclk_reg <= 1'b0;
      cnt_reg <= 8'h00;
      bits_reg <= 5'h00;
      hshift_reg <= 16'h0000;
      seen_reg <= 1'b0;
      result <= 16'h0000;
      result_valid <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      if (busy_rise) seen_reg <= 1'b1;
      case (state_reg)
        sar_link_pkg::H_IDLE: begin
          if (start) begin
            link.convert_start_n <= 1'b0;
            cnt_reg <= `CNV_PULSE;
            seen_reg <= 1'b0;
            state_reg <= sar_link_pkg::H_CNV;
          end
        end
        sar_link_pkg::H_CNV: begin
          cnt_reg <= cnt_reg - 8'h01;
          if (cnt_reg == 8'h01) begin
            link.convert_start_n <= !auto_repeat;
            state_reg <= sar_link_pkg::H_WAIT;
          end
        end
        sar_link_pkg::H_WAIT: begin
          if (seen_reg && busy_fall) begin
            cnt_reg <= ext_clock ? `HSCLK_HALF : `PAR_SETTLE;
            bits_reg <= 5'h00;
            state_reg <= sar_link_pkg::H_READ;
          end
        end
        sar_link_pkg::H_READ: begin
          if (host_master) begin
            if (mcnt_reg == `WORD_BITS || !use_serial) begin
              result <= mshift_reg;
              result_valid <= 1'b1;
              seen_reg <= 1'b0;
              state_reg <= auto_repeat ? sar_link_pkg::H_WAIT : sar_link_pkg::H_IDLE;
            end
          end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
          end else if (!use_serial) begin
            result <= byte_swap ? {in_lvl[7:0], in_lvl[15:8]} : in_lvl[15:0];
            result_valid <= 1'b1;
            seen_reg <= 1'b0;
            state_reg <= auto_repeat ? sar_link_pkg::H_WAIT : sar_link_pkg::H_IDLE;
          end else begin
            cnt_reg <= `HSCLK_HALF;
            hsclk_reg <= !hsclk_reg;
            link.ext_sclk <= !hsclk_reg;
            if (!hsclk_reg) begin
              hshift_reg <= {hshift_reg[14:0], in_lvl[17]};
              bits_reg <= bits_reg + 5'h01;
            end else if (bits_reg == `WORD_BITS) begin
              result <= hshift_reg;
              result_valid <= 1'b1;
              seen_reg <= 1'b0;
              state_reg <= auto_repeat ? sar_link_pkg::H_WAIT : sar_link_pkg::H_IDLE;
            end
          end
        end
        default: state_reg <= sar_link_pkg::H_IDLE;
      endcase
      if (!auto_repeat && state_reg != sar_link_pkg::H_CNV && state_reg != sar_link_pkg::H_IDLE) begin
        link.convert_start_n <= 1'b1;
      end
    end
  end
endmodule : sar_readout_host

// ==== dv/sar_link_asserts.sv ====
// Concurrent checks on the pins between converter end and host end.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/10ps
module sar_link_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host driven pins
  input wire logic convert_start_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic serial_parallel_select,
  input wire logic clock_source_select,
  input wire logic read_mode_or_chain_in,
  input wire logic sync_invert,
  input wire logic [1:0] speed_mode,
  // Device driven pins
  input wire logic data_oe,
  input wire logic serial_oe,
  input wire logic sync_out,
  input wire logic busy,
  input wire logic read_overrun_flag
);
  logic [8:0] busy_len;
  logic [8:0] sync_len;
  logic sync_active;
  assign sync_active = sync_out ^ sync_invert;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk) begin
    if (rst || !busy) begin
      busy_len <= 9'h000;
    end else begin
      busy_len <= busy_len + 9'h001;
    end
  end
  always_ff @(posedge clk) begin
    if (rst || !sync_active) begin
      sync_len <= 9'h000;
    end else begin
      sync_len <= sync_len + 9'h001;
    end
  end
  AST_HIZ_DESELECTED: assert property ((cs_n | rd_n)[*6] |-> !data_oe && !serial_oe)
    else $error("outputs driven while deselected");
  AST_PAR_ONLY: assert property (serial_parallel_select[*6] |-> !data_oe)
    else $error("parallel bus driven in serial mode");
  AST_SER_ONLY: assert property ((!serial_parallel_select)[*6] |-> !serial_oe)
    else $error("serial pin driven in parallel mode");
  AST_BUSY_WIDTH: assert property ($fell(busy) |-> busy_len >= 9'h0C8)
    else $error("conversion shorter than its full time");
  AST_NO_AUTO_FAST: assert property ($rose(busy) && speed_mode != 2'h2 |-> $past(convert_start_n, 8))
    else $error("conversion without a new start edge");
  AST_AUTO_REPEAT: assert property ($fell(busy) && !convert_start_n && speed_mode == 2'h2 |-> ##[45:60] $rose(busy))
    else $error("held start did not repeat conversion");
  AST_OVERRUN_END: assert property (read_overrun_flag |-> !busy && ($past(busy) || $past(busy, 2)) ##1 !read_overrun_flag)
    else $error("overrun pulse not at conversion end");
  // Short blips follow a polarity change, while the far end resynchronises it
  AST_SYNC_LEN: assert property ($fell(sync_active) && sync_len > 9'h010 |-> sync_len inside {[9'h07F:9'h080]})
    else $error("sync frame not sixteen bits long");
  // Busy drops with the last shift; sync follows one cycle later
  AST_MASTER_BUSY: assert property ($fell(busy) && !clock_source_select && !read_mode_or_chain_in && serial_parallel_select |-> ##1 $fell(sync_active))
    else $error("busy fell before master transfer end");
endmodule : sar_link_asserts

// ==== dv/test_sar_adc_conversion_readout_interface.sv ====
// Bench joining host end and converter end over the link interface.
// Assumes a 250 MHz clock and a synchronous active-high reset.
`timescale 1ns/10ps
module test_sar_adc_conversion_readout_interface;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0, auto_repeat = 1'b0, use_serial = 1'b0, ext_clock = 1'b0;
  logic read_during = 1'b0, invert_master = 1'b0, pd_request = 1'b0, byte_swap = 1'b0;
  logic straight_binary = 1'b1;
  logic [1:0] speed = 2'h0;
  logic [15:0] sample_value = 16'h0000;
  logic [15:0] result, bus_word;
  logic result_valid, overrun_seen, low_power_idle, busy_d;
  int num_errors = 0, checks = 0, rises = 0, r;
  sar_link_if link();
  sar_readout_device sar_readout_device_i (.clk(clk), .rst(rst), .link(link),
    .sample_value(sample_value), .low_power_idle(low_power_idle));
  sar_readout_host sar_readout_host_i (.clk(clk), .rst(rst), .link(link), .start(start),
    .auto_repeat(auto_repeat), .use_serial(use_serial), .ext_clock(ext_clock),
    .read_during(read_during), .invert_master(invert_master), .pd_request(pd_request),
    .byte_swap(byte_swap), .straight_binary(straight_binary), .speed(speed),
    .result(result), .result_valid(result_valid), .overrun_seen(overrun_seen));
  sar_link_asserts sar_link_asserts_i (.clk(clk), .rst(rst),
    .convert_start_n(link.convert_start_n), .cs_n(link.cs_n), .rd_n(link.rd_n),
    .serial_parallel_select(link.serial_parallel_select),
    .clock_source_select(link.clock_source_select),
    .read_mode_or_chain_in(link.read_mode_or_chain_in), .sync_invert(link.sync_invert),
    .speed_mode(link.speed_mode), .data_oe(link.data_oe), .serial_oe(link.serial_oe),
    .sync_out(link.sync_out), .busy(link.busy), .read_overrun_flag(link.read_overrun_flag));
  always #2 clk = ~clk;
  // Last driven bus word and count of conversion starts
  always @(posedge clk) begin
    if (link.data_oe === 1'b1) bus_word <= link.data_out;
    if (link.busy === 1'b1 && busy_d !== 1'b1) rises <= rises + 1;
    busy_d <= link.busy;
  end
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wait_valid;
    int n;
    n = 0;
    @(negedge clk);
    while (result_valid !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check("result_valid", 16'h0000, (n >= 3000) ? 16'h0001 : 16'h0000);
  endtask : wait_valid
  // Mode bits: serial, external clock, read during, byte swap, straight binary
  task automatic run(input logic [4:0] mode, input logic [1:0] spd, input logic [15:0] smp);
    logic [15:0] code;
    @(negedge clk);
    {use_serial, ext_clock, read_during, byte_swap, straight_binary} = mode;
    speed = spd;
    sample_value = smp;
    code = mode[0] ? smp : {~smp[15], smp[14:0]};
    repeat (6) @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    wait_valid();
    if (!mode[4]) check("data_out", mode[1] ? {code[7:0], code[15:8]} : code, bus_word);
    if (mode[4] || !mode[1]) check("result", code, result);
  endtask : run
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    run(5'b00001, 2'h0, 16'hA5C3);
    run(5'b00010, 2'h1, 16'h8001);
    run(5'b11001, 2'h0, 16'h1234);
    run(5'b11000, 2'h1, 16'hFFFE);
    run(5'b10001, 2'h0, 16'h6ED9);
    invert_master = 1'b1;
    run(5'b10001, 2'h1, 16'h6ED9);
    run(5'b10101, 2'h0, 16'h6ED9);
    invert_master = 1'b0;
    auto_repeat = 1'b1;
    run(5'b00001, 2'h2, 16'h0F0F);
    wait_valid();
    check("repeat", 16'h0F0F, result);
    r = rises;
    while (rises == r) @(negedge clk);
    // Release during conversion so the held-start check stays honest
    auto_repeat = 1'b0;
    repeat (700) @(negedge clk);
    check("low_power_idle", 16'h0001, {15'h0000, low_power_idle});
    pd_request = 1'b1;
    repeat (6) @(negedge clk);
    r = rises;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (400) @(negedge clk);
    check("pd_starts", 16'(r), 16'(rises));
    // Host may still wait for busy, so reset both ends
    rst = 1'b1;
    pd_request = 1'b0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    auto_repeat = 1'b1;
    run(5'b00001, 2'h0, 16'h3C3C);
    r = rises;
    repeat (600) @(negedge clk);
    check("warp_repeat", 16'(r), 16'(rises));
    stop_test();
  end
endmodule : test_sar_adc_conversion_readout_interface
